// *** hdl/pwr_mode_ctrl.sv ***
// Chip power mode controller: run, wait, stop and leakage modes,
// clock enables, retention controls and recovery paths.
// Assumes core inputs are on clk_sys; wake pins are asynchronous.

// How it works
// - Pin states are held whenever the chip is outside its run state.
// - Only the wait-for-interrupt pulse moves the chip into a sleep mode.
// - Full-speed and low-power run modes each pick their own wait and stop flavour at entry.
// - Full run gives 48 MHz core, 24 MHz bus and flash, peripherals on.
// - Compute-only run keeps the 48 MHz core with bus and flash off.
// - Low-power compute-only run gives a 4 MHz core, bus and flash off.
// - Wait stops the core, system 48 MHz, bus 24 MHz, flash and periph off.
// - Low-power wait stops the core, system 4 MHz, bus 0.8 MHz.
// - Stop turns off all clocks, keeps state and low-voltage detect.
// - Low-power halt drops low-voltage detect, keeps ADC and pin wake.
// - Low-leakage halt drops the interrupt controller; wake-up unit only.
// - Waking from the SRAM-kept leakage mode runs a reset, SRAM kept.
// - The register-file leakage mode drops SRAM but keeps 32 bytes.
// - Deepest mode stops the oscillator, reset optional, wakes by reset.
// - In wait, stop and low-power halt, any unmasked interrupt requests wake-up.
module pwr_mode_ctrl #(
	parameter int unsigned N = pwr_pkg::IRQ_NUM
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Core requests
	input wire logic wfi_exec,
	input wire logic sleep_deep,
	input wire pwr_pkg::pwr_halt_sel_t halt_sel,
	input wire logic vlp_sel,
	input wire logic compute_only_sel,
	input wire logic por_keep_on,
	// Wake sources
	input wire logic [N-1:0] irq_line,
	input wire logic [N-1:0] irq_mask,
	input wire logic leakage_wakeup_pin,
	// System register file
	input wire logic regf_we,
	input wire logic [4:0] regf_addr,
	input wire logic [7:0] regf_wdata,
	output logic [7:0] regf_rdata,
	// Clock enables
	output logic core_clk_en,
	output logic sys_clk_en,
	output logic bus_clk_en,
	output logic flash_clk_en,
	output logic periph_clk_en,
	// Power and retention controls
	output logic io_hold,
	output logic low_voltage_detect_en,
	output logic adc_pin_wake_en,
	output logic nested_irq_ctrl_en,
	output logic sram_retain,
	output logic regfile_retain,
	output logic low_power_osc_en,
	output logic por_en,
	// Status
	output logic wake_reset,
	output logic core_resume,
	output pwr_pkg::pwr_mode_t mode
);
	pwr_pkg::pwr_state_t state_q, state_d;
	pwr_pkg::pwr_mode_t mode_q, mode_d, ctx_q, ctx_d;
	logic [3:0] cnt_q, cnt_d;
	logic [11:0] sys_acc_q, bus_acc_q;
	logic [12:0] sys_step, bus_step;
	logic leakage_wakeup_unit_s1_q, leakage_wakeup_unit_s2_q;
	logic [7:0] regf_q [pwr_pkg::REGFILE_BYTES];
	logic core_en_q, sys_en_q, bus_en_q, flash_en_q, periph_en_q;
	logic hold_q, lvd_q, adc_q, nested_interrupt_controller_q, sram_q, regf_ret_q;
	logic lpo_q, por_q, wrst_q, resume_q;
	wire pwr_pkg::pwr_clk_cfg_t cfg;
	wire pwr_pkg::pwr_mode_t run_mode, entry_mode;
	wire logic in_run, in_sleep, wic_path, wake_now, via_reset;
	pwr_wic_if #(.N(N)) wif ();

	// Clock plan of each mode
	function automatic pwr_pkg::pwr_clk_cfg_t clk_cfg(pwr_pkg::pwr_mode_t m);
		case (m)
			pwr_pkg::M_RUN: clk_cfg = 6'b110111;
			pwr_pkg::M_COMPUTE_ONLY_RUN: clk_cfg = 6'b110000;
			pwr_pkg::M_VERY_LOW_POWER_RUN: clk_cfg = 6'b111111;
			pwr_pkg::M_LOW_POWER_COMPUTE_ONLY_RUN: clk_cfg = 6'b111000;
			pwr_pkg::M_WAIT: clk_cfg = 6'b010100;
			pwr_pkg::M_VERY_LOW_POWER_WAIT: clk_cfg = 6'b011100;
			default: clk_cfg = 6'b000000;
		endcase
	endfunction

	// Fractional divider step: {tick, next accumulator}
	function automatic logic [12:0] acc_step(logic [11:0] acc,
			logic [11:0] rate, logic on);
		logic [12:0] sum;
		sum = {1'b0, acc} + {1'b0, rate};
		if (!on)
			acc_step = 13'h0000;
		else if (sum >= {1'b0, pwr_pkg::SYS_RATE})
			acc_step = {1'b1, 12'(sum - {1'b0, pwr_pkg::SYS_RATE})};
		else
			acc_step = {1'b0, sum[11:0]};
	endfunction

	function automatic logic is_slow(pwr_pkg::pwr_mode_t m);
		is_slow = m == pwr_pkg::M_VERY_LOW_POWER_RUN ||
			m == pwr_pkg::M_LOW_POWER_COMPUTE_ONLY_RUN;
	endfunction

	// Wake-up interrupt controller
	pwr_wic #(.N(N)) u_wic (
		.clk_sys(clk_sys),
		.rst(rst),
		.irq_line(irq_line),
		.wic(wif.wic)
	);

	// Mode decoding
	assign cfg = clk_cfg(mode_q);
	assign in_run = state_q == pwr_pkg::S_RUN;
	assign in_sleep = state_q == pwr_pkg::S_SLEEP;
	assign run_mode = vlp_sel ?
		(compute_only_sel ? pwr_pkg::M_LOW_POWER_COMPUTE_ONLY_RUN :
			pwr_pkg::M_VERY_LOW_POWER_RUN) :
		(compute_only_sel ? pwr_pkg::M_COMPUTE_ONLY_RUN : pwr_pkg::M_RUN);
	assign entry_mode = !sleep_deep ?
		(is_slow(mode_q) ? pwr_pkg::M_VERY_LOW_POWER_WAIT : pwr_pkg::M_WAIT) :
		halt_sel == pwr_pkg::H_STOP ?
		(is_slow(mode_q) ? pwr_pkg::M_VERY_LOW_POWER_HALT : pwr_pkg::M_STOP) :
		halt_sel == pwr_pkg::H_LOW_LEAKAGE ? pwr_pkg::M_LOW_LEAKAGE_HALT :
		halt_sel == pwr_pkg::H_SRAM_KEPT ? pwr_pkg::M_LEAKAGE_HALT_SRAM_KEPT :
		halt_sel == pwr_pkg::H_REGFILE_KEPT ?
		pwr_pkg::M_LEAKAGE_HALT_REGFILE_KEPT : pwr_pkg::M_LEAKAGE_HALT_DEEPEST;
	// interrupt path only in wait, stop and low-power halt modes
	assign wic_path = mode_q < pwr_pkg::M_LOW_LEAKAGE_HALT;
	assign wake_now = in_sleep && (wic_path ? wif.wake_req : leakage_wakeup_unit_s2_q);
	// leakage modes beyond low-leakage wake via reset
	assign via_reset = mode_q > pwr_pkg::M_LOW_LEAKAGE_HALT;
	// arm while sleeping in wait, stop or low-power halt
	assign wif.armed = in_sleep && wic_path;
	assign wif.mask = irq_mask;

	// Sequencer
	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		ctx_d = ctx_q;
		cnt_d = cnt_q;
		case (state_q)
			pwr_pkg::S_RUN: begin
				mode_d = run_mode;
				if (wfi_exec) begin
					state_d = pwr_pkg::S_SLEEP;
					mode_d = entry_mode;
					ctx_d = mode_q;
				end
			end
			pwr_pkg::S_SLEEP: begin
				if (wake_now && via_reset) begin
					state_d = pwr_pkg::S_WAKE_RESET;
					cnt_d = 4'(pwr_pkg::WAKE_RST_CYC - 1);
				end else if (wake_now) begin
					state_d = pwr_pkg::S_RESTORE;
					mode_d = ctx_q;
					cnt_d = 4'(pwr_pkg::RESTORE_CYC - 1);
				end
			end
			pwr_pkg::S_RESTORE: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h0) begin
					state_d = pwr_pkg::S_RUN;
				end
			end
			pwr_pkg::S_WAKE_RESET: begin
				cnt_d = cnt_q - 4'h1;
				mode_d = pwr_pkg::M_RUN;
				if (cnt_q == 4'h0) begin
					state_d = pwr_pkg::S_RUN;
				end
			end
			default: state_d = pwr_pkg::S_RUN;
		endcase
	end

	// State registers and wake pin synchroniser
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= pwr_pkg::S_RUN;
			mode_q <= pwr_pkg::M_RUN;
			ctx_q <= pwr_pkg::M_RUN;
			cnt_q <= 4'h0;
			leakage_wakeup_unit_s1_q <= 1'b0;
			leakage_wakeup_unit_s2_q <= 1'b0;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			ctx_q <= ctx_d;
			cnt_q <= cnt_d;
			leakage_wakeup_unit_s1_q <= leakage_wakeup_pin;
			leakage_wakeup_unit_s2_q <= leakage_wakeup_unit_s1_q;
		end
	end

	// Rate dividers for system/core and bus/flash
	assign sys_step = acc_step(sys_acc_q,
		cfg.slow ? pwr_pkg::RATE_CORE_SLOW : pwr_pkg::RATE_CORE_FULL,
		cfg.sys_on);
	assign bus_step = acc_step(bus_acc_q,
		cfg.slow ? pwr_pkg::RATE_BUS_SLOW : pwr_pkg::RATE_BUS_FULL,
		cfg.bus_on);

	// Gated clock enable pulses; core held off until run
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sys_acc_q <= 12'h000;
			bus_acc_q <= 12'h000;
			core_en_q <= 1'b0;
			sys_en_q <= 1'b0;
			bus_en_q <= 1'b0;
			flash_en_q <= 1'b0;
			periph_en_q <= 1'b0;
		end else begin
			sys_acc_q <= sys_step[11:0];
			bus_acc_q <= bus_step[11:0];
			core_en_q <= sys_step[12] && cfg.core_on && in_run;
			sys_en_q <= sys_step[12];
			bus_en_q <= bus_step[12];
			flash_en_q <= bus_step[12] && cfg.flash_on;
			periph_en_q <= bus_step[12] && cfg.periph_on;
		end
	end

	// Power, retention and status controls
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hold_q <= 1'b0;
			lvd_q <= 1'b1;
			adc_q <= 1'b1;
			nested_interrupt_controller_q <= 1'b1;
			sram_q <= 1'b1;
			regf_ret_q <= 1'b1;
			lpo_q <= 1'b1;
			por_q <= 1'b1;
			wrst_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			hold_q <= state_d != pwr_pkg::S_RUN;
			// detector off only in low-power halt
			lvd_q <= mode_d != pwr_pkg::M_VERY_LOW_POWER_HALT;
			adc_q <= mode_d < pwr_pkg::M_LOW_LEAKAGE_HALT;
			nested_interrupt_controller_q <= mode_d < pwr_pkg::M_LOW_LEAKAGE_HALT;
			// SRAM lost from register-file mode down
			sram_q <= mode_d < pwr_pkg::M_LEAKAGE_HALT_REGFILE_KEPT;
			regf_ret_q <= mode_d != pwr_pkg::M_LEAKAGE_HALT_DEEPEST;
			lpo_q <= mode_d != pwr_pkg::M_LEAKAGE_HALT_DEEPEST;
			por_q <= mode_d != pwr_pkg::M_LEAKAGE_HALT_DEEPEST || por_keep_on;
			wrst_q <= state_d == pwr_pkg::S_WAKE_RESET;
			resume_q <= state_q == pwr_pkg::S_RESTORE &&
				state_d == pwr_pkg::S_RUN;
		end
	end

	// register file survives wake reset; cleared only by rst
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < pwr_pkg::REGFILE_BYTES; i++) begin
				regf_q[i] <= pwr_pkg::REGFILE_RST;
			end
			regf_rdata <= pwr_pkg::REGFILE_RST;
		end else begin
			if (regf_we && in_run) begin
				regf_q[regf_addr] <= regf_wdata;
			end
			regf_rdata <= regf_q[regf_addr];
		end
	end

	// Output wiring
	assign core_clk_en = core_en_q;
	assign sys_clk_en = sys_en_q;
	assign bus_clk_en = bus_en_q;
	assign flash_clk_en = flash_en_q;
	assign periph_clk_en = periph_en_q;
	assign io_hold = hold_q;
	assign low_voltage_detect_en = lvd_q;
	assign adc_pin_wake_en = adc_q;
	assign nested_irq_ctrl_en = nested_interrupt_controller_q;
	assign sram_retain = sram_q;
	assign regfile_retain = regf_ret_q;
	assign low_power_osc_en = lpo_q;
	assign por_en = por_q;
	assign wake_reset = wrst_q;
	assign core_resume = resume_q;
	assign mode = mode_q;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_hold;
		!in_run |-> io_hold;
	endproperty
	a_hold: assert property (p_hold)
		else $error("pins not held outside run");

	property p_entry;
		in_run && !wfi_exec |=> in_run;
	endproperty
	a_entry: assert property (p_entry)
		else $error("left run without wait instruction");

	property p_ctx;
		in_run && wfi_exec && !sleep_deep && is_slow(mode_q)
		|=> mode_q == pwr_pkg::M_VERY_LOW_POWER_WAIT;
	endproperty
	a_ctx: assert property (p_ctx)
		else $error("slow run did not enter slow wait");

	property p_co;
		in_run && mode_q == pwr_pkg::M_COMPUTE_ONLY_RUN
		|=> !flash_clk_en && !bus_clk_en;
	endproperty
	a_co: assert property (p_co)
		else $error("bus clock in compute-only run");

	sequence s_full;
		(in_run && mode_q == pwr_pkg::M_RUN)[*6];
	endsequence
	property p_full;
		// Leaving full run inside the window ends the obligation
		s_full |-> ##[1:6] ((flash_clk_en && periph_clk_en && bus_clk_en) ||
			!in_run || mode_q != pwr_pkg::M_RUN);
	endproperty
	a_full: assert property (p_full)
		else $error("no bus tick in full run");

	property p_wait;
		in_sleep && mode_q == pwr_pkg::M_WAIT
		|=> !core_clk_en && !flash_clk_en && !periph_clk_en;
	endproperty
	a_wait: assert property (p_wait)
		else $error("core or flash clock in wait");

	property p_stop;
		in_sleep && mode_q == pwr_pkg::M_STOP
		|=> !sys_clk_en && !bus_clk_en && low_voltage_detect_en;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop clocks or detector wrong");

	property p_vlp_halt;
		in_sleep && mode_q == pwr_pkg::M_VERY_LOW_POWER_HALT
		|-> !low_voltage_detect_en && adc_pin_wake_en;
	endproperty
	a_vlp_halt: assert property (p_vlp_halt)
		else $error("low-power halt controls wrong");

	property p_ll;
		in_sleep && mode_q == pwr_pkg::M_LOW_LEAKAGE_HALT && !leakage_wakeup_unit_s2_q
		|=> in_sleep && !nested_irq_ctrl_en;
	endproperty
	a_ll: assert property (p_ll)
		else $error("low-leakage halt woke without wake-up unit");

	property p_sram_wake;
		in_sleep && mode_q == pwr_pkg::M_LEAKAGE_HALT_SRAM_KEPT && leakage_wakeup_unit_s2_q
		|=> wake_reset && sram_retain ##1 wake_reset;
	endproperty
	a_sram_wake: assert property (p_sram_wake)
		else $error("SRAM-kept wake did not run reset");

	property p_deepest;
		in_sleep && mode_q == pwr_pkg::M_LEAKAGE_HALT_DEEPEST
		|-> !low_power_osc_en && por_en == $past(por_keep_on);
	endproperty
	a_deepest: assert property (p_deepest)
		else $error("deepest mode oscillator or reset wrong");

	property p_restore;
		state_q == pwr_pkg::S_RESTORE && cnt_q == 4'h0
		|=> in_run && mode_q == $past(ctx_q) && core_resume;
	endproperty
	a_restore: assert property (p_restore)
		else $error("recovery did not restore entry mode");

endmodule

// *** hdl/pwr_wic.sv ***
// Wake-up interrupt controller: flat masking, no priority.
// Assumes interrupt lines may come from other domains or pins.
module pwr_wic #(
	parameter int unsigned N = pwr_pkg::IRQ_NUM
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Raw interrupt lines
	input wire logic [N-1:0] irq_line,
	// Controller side
	pwr_wic_if.wic wic
);
	logic [N-1:0] irq_s1_q;
	logic [N-1:0] irq_s2_q;
	logic wake_q;
	wire logic hit;

	// Two-stage synchroniser
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_s1_q <= '0;
			irq_s2_q <= '0;
		end else begin
			irq_s1_q <= irq_line;
			irq_s2_q <= irq_s1_q;
		end
	end

	assign hit = wic.armed && |(irq_s2_q & ~wic.mask);

	// Registered wake request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= hit;
		end
	end

	assign wic.wake_req = wake_q;

	property p_wic_wake;
		@(posedge clk_sys) disable iff (rst)
		(wic.armed && |(irq_s2_q & ~wic.mask)) |=> wic.wake_req;
	endproperty
	a_wic_wake: assert property (p_wic_wake)
		else $error("unmasked interrupt gave no wake request");

	property p_wic_quiet;
		@(posedge clk_sys) disable iff (rst)
		(!wic.armed || (irq_s2_q & ~wic.mask) == '0) |=> !wic.wake_req;
	endproperty
	a_wic_quiet: assert property (p_wic_quiet)
		else $error("wake request without unmasked interrupt");

endmodule

// *** inc/pwr_pkg.sv ***
// Shared constants and types of the chip power mode controller.
// Assumes a single 125 MHz clk_sys and a synchronous active-high reset.
package pwr_pkg;

	// Clock rates in units of 100 kHz
	localparam logic [11:0] SYS_RATE = 12'h4e2;     // 125 MHz clk_sys
	localparam logic [11:0] RATE_CORE_FULL = 12'h1e0; // 48 MHz
	localparam logic [11:0] RATE_BUS_FULL = 12'h0f0;  // 24 MHz
	localparam logic [11:0] RATE_CORE_SLOW = 12'h028; // 4 MHz
	localparam logic [11:0] RATE_BUS_SLOW = 12'h008;  // 0.8 MHz

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned RESTORE_NS = 40;
	localparam int unsigned RESTORE_CYC =
		(RESTORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAKE_RST_NS = 80;
	localparam int unsigned WAKE_RST_CYC =
		(WAKE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Sizes
	localparam int unsigned IRQ_NUM = 32;
	localparam int unsigned REGFILE_BYTES = 32;
	localparam logic [7:0] REGFILE_RST = 8'h00;

	typedef enum logic [3:0] {
		M_RUN = 4'h0,
		M_COMPUTE_ONLY_RUN = 4'h1,
		M_VERY_LOW_POWER_RUN = 4'h2,
		M_LOW_POWER_COMPUTE_ONLY_RUN = 4'h3,
		M_WAIT = 4'h4,
		M_VERY_LOW_POWER_WAIT = 4'h5,
		M_STOP = 4'h6,
		M_VERY_LOW_POWER_HALT = 4'h7,
		M_LOW_LEAKAGE_HALT = 4'h8,
		M_LEAKAGE_HALT_SRAM_KEPT = 4'h9,
		M_LEAKAGE_HALT_REGFILE_KEPT = 4'ha,
		M_LEAKAGE_HALT_DEEPEST = 4'hb
	} pwr_mode_t;

	// Deep-sleep flavour chosen by software before the wait instruction
	typedef enum logic [2:0] {
		H_STOP = 3'h0,
		H_LOW_LEAKAGE = 3'h1,
		H_SRAM_KEPT = 3'h2,
		H_REGFILE_KEPT = 3'h3,
		H_DEEPEST = 3'h4
	} pwr_halt_sel_t;

	typedef enum logic [1:0] {
		S_RUN = 2'h0,
		S_SLEEP = 2'h1,
		S_RESTORE = 2'h2,
		S_WAKE_RESET = 2'h3
	} pwr_state_t;

	typedef struct packed {
		logic core_on;
		logic sys_on;
		logic slow;
		logic bus_on;
		logic flash_on;
		logic periph_on;
	} pwr_clk_cfg_t;

endpackage

// *** inc/pwr_wic_if.sv ***
// Link between the mode controller and its wake-up interrupt controller.
// Both ends run on clk_sys.
interface pwr_wic_if #(
	parameter int unsigned N = pwr_pkg::IRQ_NUM
);
	logic armed;
	logic [N-1:0] mask;
	logic wake_req;

	modport ctrl (output armed, output mask, input wake_req);
	modport wic (input armed, input mask, output wake_req);
endinterface

// *** sim/power_mode_controller_test.sv ***
// Self-checking bench of the chip power mode controller.
// Assumes pwr_core_model as the core and a 125 MHz clk_sys.
module power_mode_controller_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned N = pwr_pkg::IRQ_NUM;
	localparam int CF = int'(pwr_pkg::RATE_CORE_FULL);
	localparam int BF = int'(pwr_pkg::RATE_BUS_FULL);
	localparam int CS = int'(pwr_pkg::RATE_CORE_SLOW);
	localparam int BS = int'(pwr_pkg::RATE_BUS_SLOW);
	// Row: run selects, sleep request, mode, pulses per 1250 cycles, levels
	typedef struct {
		logic vlp;
		logic co;
		logic deep;
		pwr_pkg::pwr_halt_sel_t hsel;
		pwr_pkg::pwr_mode_t mode;
		int e [5];
		logic [5:0] lv;
		logic [5:0] lm;
		int wake;
	} pwr_row_t;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic sleep_deep = 1'b0;
	pwr_pkg::pwr_halt_sel_t halt_sel = pwr_pkg::H_STOP;
	logic vlp_sel = 1'b0;
	logic compute_only_sel = 1'b0;
	logic por_keep_on = 1'b0;
	logic [N-1:0] irq_mask = '0;
	logic regf_we = 1'b0;
	logic [4:0] regf_addr = 5'h00;
	logic [7:0] regf_wdata = 8'h00;
	logic wfi_exec, leakage_wakeup_pin, wake_reset, core_resume, io_hold;
	logic [N-1:0] irq_line;
	logic [7:0] regf_rdata, rd;
	logic core_clk_en, sys_clk_en, bus_clk_en, flash_clk_en, periph_clk_en;
	logic low_voltage_detect_en, adc_pin_wake_en, nested_irq_ctrl_en;
	logic sram_retain, regfile_retain, low_power_osc_en, por_en;
	pwr_pkg::pwr_mode_t mode;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	int cnt [5];
	string en_nm [5] = '{"core clk", "sys clk", "bus clk", "flash clk",
		"periph clk"};
	pwr_row_t rr [4] = '{
		'{1'b0, 1'b0, 1'b0, pwr_pkg::H_STOP, pwr_pkg::M_RUN,
			'{CF, -1, BF, BF, -2}, 6'h00, 6'h00, 0},
		'{1'b0, 1'b1, 1'b0, pwr_pkg::H_STOP, pwr_pkg::M_COMPUTE_ONLY_RUN,
			'{CF, -1, 0, 0, 0}, 6'h00, 6'h00, 0},
		'{1'b1, 1'b0, 1'b0, pwr_pkg::H_STOP, pwr_pkg::M_VERY_LOW_POWER_RUN,
			'{-1, -1, -1, -1, -1}, 6'h00, 6'h00, 0},
		'{1'b1, 1'b1, 1'b0, pwr_pkg::H_STOP,
			pwr_pkg::M_LOW_POWER_COMPUTE_ONLY_RUN,
			'{CS, -1, 0, 0, 0}, 6'h00, 6'h00, 0}};
	pwr_row_t sl [8] = '{
		'{1'b0, 1'b0, 1'b0, pwr_pkg::H_STOP, pwr_pkg::M_WAIT,
			'{0, CF, BF, 0, 0}, 6'h3f, 6'h3f, 0},
		'{1'b1, 1'b0, 1'b0, pwr_pkg::H_STOP, pwr_pkg::M_VERY_LOW_POWER_WAIT,
			'{0, CS, BS, 0, 0}, 6'h3f, 6'h3f, 0},
		'{1'b0, 1'b0, 1'b1, pwr_pkg::H_STOP, pwr_pkg::M_STOP,
			'{0, 0, 0, 0, 0}, 6'h3f, 6'h3f, 0},
		'{1'b1, 1'b0, 1'b1, pwr_pkg::H_STOP, pwr_pkg::M_VERY_LOW_POWER_HALT,
			'{0, 0, 0, 0, 0}, 6'h1f, 6'h3f, 0},
		'{1'b0, 1'b0, 1'b1, pwr_pkg::H_LOW_LEAKAGE,
			pwr_pkg::M_LOW_LEAKAGE_HALT, '{0, 0, 0, 0, 0}, 6'h27, 6'h2f, 1},
		'{1'b0, 1'b0, 1'b1, pwr_pkg::H_SRAM_KEPT,
			pwr_pkg::M_LEAKAGE_HALT_SRAM_KEPT, '{0, 0, 0, 0, 0}, 6'h07, 6'h07, 2},
		'{1'b0, 1'b0, 1'b1, pwr_pkg::H_REGFILE_KEPT,
			pwr_pkg::M_LEAKAGE_HALT_REGFILE_KEPT,
			'{0, 0, 0, 0, 0}, 6'h03, 6'h07, 2},
		'{1'b0, 1'b0, 1'b1, pwr_pkg::H_DEEPEST,
			pwr_pkg::M_LEAKAGE_HALT_DEEPEST, '{0, 0, 0, 0, 0}, 6'h00, 6'h07, 2}};
	wire logic [4:0] en = {periph_clk_en, flash_clk_en, bus_clk_en,
		sys_clk_en, core_clk_en};
	wire logic [5:0] lvl = {low_voltage_detect_en, adc_pin_wake_en,
		nested_irq_ctrl_en, sram_retain, regfile_retain, low_power_osc_en};

	// Clock generation
	always #4 clk_sys = ~clk_sys;

	// Device under test
	pwr_mode_ctrl #(.N(N)) u_dut (.clk_sys(clk_sys), .rst(rst),
		.wfi_exec(wfi_exec), .sleep_deep(sleep_deep), .halt_sel(halt_sel),
		.vlp_sel(vlp_sel), .compute_only_sel(compute_only_sel),
		.por_keep_on(por_keep_on), .irq_line(irq_line), .irq_mask(irq_mask),
		.leakage_wakeup_pin(leakage_wakeup_pin), .regf_we(regf_we),
		.regf_addr(regf_addr), .regf_wdata(regf_wdata),
		.regf_rdata(regf_rdata), .core_clk_en(core_clk_en),
		.sys_clk_en(sys_clk_en), .bus_clk_en(bus_clk_en),
		.flash_clk_en(flash_clk_en), .periph_clk_en(periph_clk_en),
		.io_hold(io_hold), .low_voltage_detect_en(low_voltage_detect_en),
		.adc_pin_wake_en(adc_pin_wake_en),
		.nested_irq_ctrl_en(nested_irq_ctrl_en), .sram_retain(sram_retain),
		.regfile_retain(regfile_retain), .low_power_osc_en(low_power_osc_en),
		.por_en(por_en), .wake_reset(wake_reset), .core_resume(core_resume),
		.mode(mode));

	// Core and wake sources
	pwr_core_model #(.N(N)) u_core (.clk_sys(clk_sys), .rst(rst),
		.io_hold(io_hold), .wfi_exec(wfi_exec), .irq_line(irq_line),
		.leakage_wakeup_pin(leakage_wakeup_pin));

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Pulse count within tolerance; -2 means any nonzero count
	function automatic logic [15:0] near(input int a, input int b);
		if (b == -2)
			return 16'(a != 0);
		return 16'(a >= b - 2 && a <= b + 2);
	endfunction

	task automatic regf_read(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1 regf_addr = a;
		@(posedge clk_sys);
		#1 d = regf_rdata;
	endtask

	// Counts enable pulses over 10 us and compares with the row
	task automatic chk_rates(input pwr_row_t r);
		cnt = '{default: 0};
		repeat (1250) begin
			@(posedge clk_sys);
			#1;
			for (int i = 0; i < 5; i++)
				if (en[i] === 1'b1)
					cnt[i]++;
		end
		for (int i = 0; i < 5; i++)
			if (r.e[i] != -1)
				check(en_nm[i], near(cnt[i], r.e[i]), 16'h1);
	endtask

	task automatic enter(input pwr_row_t r);
		@(posedge clk_sys);
		#1;
		vlp_sel = r.vlp;
		compute_only_sel = r.co;
		sleep_deep = r.deep;
		halt_sel = r.hsel;
		por_keep_on = ~por_keep_on;
		repeat (3) @(posedge clk_sys);
		u_core.issue_wfi();
		@(posedge clk_sys);
		#1;
		check("entry mode", 16'(mode), 16'(r.mode));
		check("pin hold", 16'(io_hold), 16'h1);
	endtask

	task automatic observe(input pwr_row_t r);
		int n_rst;
		int n_res;
		logic early;
		pwr_pkg::pwr_mode_t back;
		n_rst = 0;
		n_res = 0;
		early = 1'b0;
		back = r.vlp ? pwr_pkg::M_VERY_LOW_POWER_RUN : pwr_pkg::M_RUN;
		for (int t = 0; t < 60 && n_res == 0; t++) begin
			@(posedge clk_sys);
			#1;
			if (wake_reset === 1'b1)
				n_rst++;
			if (core_resume === 1'b1) begin
				n_res++;
				check("resume mode", 16'(mode), 16'(back));
			end else if (core_clk_en === 1'b1) begin
				early = 1'b1;
			end
		end
		if (r.wake == 2) begin
			check("reset len", 16'(n_rst), 16'(pwr_pkg::WAKE_RST_CYC));
			check("resumes", 16'(n_res), 16'h0);
			check("mode after", 16'(mode), 16'(pwr_pkg::M_RUN));
		end else begin
			check("resumes", 16'(n_res), 16'h1);
			check("core early", 16'(early), 16'h0);
		end
		check("pin hold", 16'(io_hold), 16'h0);
	endtask

	// Cuts a hang short
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			$display("timeout after %0d cycles", cyc);
			wrap_up();
		end
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		check("reset enables", 16'(en), 16'h0);
		check("reset flags", 16'({io_hold, wake_reset, core_resume}), 16'h0);
		check("reset levels", 16'({lvl, por_en}), 16'h7f);
		check("reset mode", 16'(mode), 16'(pwr_pkg::M_RUN));
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		regf_we = 1'b1;
		regf_addr = 5'h1f;
		regf_wdata = 8'ha5;
		@(posedge clk_sys);
		#1 regf_we = 1'b0;
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			vlp_sel = rr[i].vlp;
			compute_only_sel = rr[i].co;
			repeat (3) @(posedge clk_sys);
			#1;
			check("run mode", 16'(mode), 16'(rr[i].mode));
			chk_rates(rr[i]);
			$display("run row %0d done", i);
		end
		vlp_sel = 1'b0;
		compute_only_sel = 1'b0;
		sleep_deep = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		check("no wfi", 16'(mode), 16'(pwr_pkg::M_RUN));
		$display("no entry test done");
		for (int i = 0; i < 8; i++) begin
			enter(sl[i]);
			chk_rates(sl[i]);
			check("levels", 16'(lvl & sl[i].lm), 16'(sl[i].lv & sl[i].lm));
			if (sl[i].mode == pwr_pkg::M_LEAKAGE_HALT_DEEPEST)
				check("por", 16'(por_en), 16'(por_keep_on));
			if (sl[i].wake == 0)
				u_core.raise_irq(5);
			else
				u_core.raise_pin();
			observe(sl[i]);
			if (sl[i].mode <= pwr_pkg::M_LEAKAGE_HALT_REGFILE_KEPT) begin
				regf_read(5'h1f, rd);
				check("regfile", 16'(rd), 16'h00a5);
			end
			$display("sleep row %0d done", i);
		end
		enter(sl[0]);
		irq_mask[3] = 1'b1;
		u_core.raise_irq(3);
		sleep_deep = 1'b1;
		u_core.issue_wfi();
		repeat (20) @(posedge clk_sys);
		#1;
		check("masked", 16'(mode), 16'(pwr_pkg::M_WAIT));
		irq_mask = '0;
		observe(sl[0]);
		$display("mask test done");
		enter(sl[4]);
		u_core.raise_irq(7);
		repeat (20) @(posedge clk_sys);
		#1;
		check("irq in leak", 16'(mode), 16'(sl[4].mode));
		u_core.raise_pin();
		observe(sl[4]);
		$display("leakage irq test done");
		enter(sl[2]);
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		check("rst mode", 16'(mode), 16'(pwr_pkg::M_RUN));
		check("rst hold", 16'(io_hold), 16'h0);
		regf_read(5'h1f, rd);
		check("rst regfile", 16'(rd), 16'h0000);
		$display("mid reset test done");
		wrap_up();
	end
endmodule

// *** sim/pwr_core_model.sv ***
// Partner model: the core issuing wait-for-interrupt and the wake sources.
// Assumes clk_sys from the bench; every change lands 1 ns after an edge.
module pwr_core_model #(
	parameter int unsigned N = pwr_pkg::IRQ_NUM
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Chip status
	input wire logic io_hold,
	// Requests towards the chip
	output logic wfi_exec,
	output logic [N-1:0] irq_line,
	output logic leakage_wakeup_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic hold_q = 1'b0;

	initial begin
		wfi_exec = 1'b0;
		irq_line = '0;
		leakage_wakeup_pin = 1'b0;
	end

	// Sources stay up until the chip is back in run (request serviced)
	always @(posedge clk_sys) begin
		hold_q <= io_hold;
		if (rst || (hold_q && !io_hold)) begin
			#1;
			irq_line = '0;
			leakage_wakeup_pin = 1'b0;
		end
	end

	// One-cycle wait-for-interrupt pulse
	task automatic issue_wfi();
		@(posedge clk_sys);
		#1 wfi_exec = 1'b1;
		@(posedge clk_sys);
		#1 wfi_exec = 1'b0;
	endtask

	// Level interrupt on one line
	task automatic raise_irq(input int unsigned k);
		@(posedge clk_sys);
		#1 irq_line[k] = 1'b1;
	endtask

	// Level request to the leakage wake-up unit
	task automatic raise_pin();
		@(posedge clk_sys);
		#1 leakage_wakeup_pin = 1'b1;
	endtask
endmodule
